// ### core/isp_flash_cfg.svh
`ifndef ISP_FLASH_CFG_SVH
`define ISP_FLASH_CFG_SVH

// machine cycle length in core clocks and timed-access spans in machine cycles
`define MC_CLKS          8'd12
`define TA_ARM_MC        8'd3
`define TA_WIN_MC        8'd3
`define TA_ARM_CLKS      (`TA_ARM_MC * `MC_CLKS)
`define TA_WIN_CLKS      (`TA_WIN_MC * `MC_CLKS)

`define KEY_FIRST        8'h87
`define KEY_SECOND       8'h59

// register indices; byte address is four times the index
`define IDX_CMD          8'hc7
`define IDX_KEY          8'hf6
`define IDX_ADDR_HIGH    8'hc4
`define IDX_ADDR_LOW     8'hc5
`define IDX_DATA         8'hc6
`define IDX_CHIP_PROG    8'h9f
`define IDX_CLK_SEL      8'h8e

`define CHP_ISP_BIT      0
`define CHP_RST_BIT_A    1
`define CHP_RST_BIT_B    7
`define CMD_BANK_BIT     6
`define CMD_OE_BIT       5
`define CMD_CE_BIT       4
`define CMD_OP_MSB       3
`define CMD_WR_MASK      8'h7f

`define OP_ERASE         4'h2
`define OP_PROGRAM       4'h1
`define OP_READ          4'h0

`define LOADER_ADDR_MASK 16'h0fff
`define REG_RESET        8'h00
`define PREADY_BUSY      1'b0

`endif

// ### core/isp_flash_pkg.sv
package isp_flash_pkg;

	typedef struct packed {
		logic        bank;
		logic        oe;
		logic        ce_n;
		logic [3:0]  op;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} flash_req_t;

	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b001,
		SEQ_ISSUE = 3'b010,
		SEQ_WAIT  = 3'b100
	} seq_state_t;

	typedef enum logic [2:0] {
		KEY_LOCKED = 3'b001,
		KEY_ARMED  = 3'b010,
		KEY_OPEN   = 3'b100
	} key_state_t;

endpackage

// ### core/timed_access_gate.sv
`timescale 1ns/1ps
`include "isp_flash_cfg.svh"

module timed_access_gate
	import isp_flash_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       key_write,
	input  wire logic [7:0] key_value,
	output logic            window_open
);

	key_state_t state;
	key_state_t next_state;
	logic [7:0] count;
	logic [7:0] next_count;

	always_comb
	begin
		next_state = state;
		next_count = count;
		if (key_write)
		begin
			if (key_value == `KEY_FIRST)
			begin
				next_state = KEY_ARMED;
				next_count = 8'(`TA_ARM_CLKS - 1);
			end
			else if (key_value == `KEY_SECOND && state == KEY_ARMED)
			begin
				next_state = KEY_OPEN;
				next_count = 8'(`TA_WIN_CLKS - 1);
			end
			else
			begin
				// any other key, or a late second key, revokes write permission
				next_state = KEY_LOCKED;
				next_count = 8'h00;
			end
		end
		else
		begin
			case (state)
				KEY_ARMED, KEY_OPEN:
				begin
					if (count == 8'h00)
						next_state = KEY_LOCKED;
					else
						next_count = count - 8'h01;
				end
				KEY_LOCKED:
					next_count = 8'h00;
				default:
				begin
					next_state = KEY_LOCKED;
					next_count = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state       <= KEY_LOCKED;
			count       <= 8'h00;
			window_open <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			count       <= next_count;
			window_open <= (next_state == KEY_OPEN);
		end
	end

endmodule

// ### core/flash_op_sequencer.sv
`timescale 1ns/1ps
`include "isp_flash_cfg.svh"

module flash_op_sequencer
	import isp_flash_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       start,
	input  flash_req_t      request,
	input  wire logic       flash_done,
	input  wire logic [7:0] flash_rdata,
	output flash_req_t      flash_req,
	output logic            flash_strobe,
	output logic            busy,
	output logic            finish,
	output logic            read_valid,
	output logic [7:0]      read_byte
);

	seq_state_t state;
	seq_state_t next_state;
	flash_req_t next_req;
	logic       next_strobe;
	logic       next_finish;
	logic       next_read_valid;
	logic [7:0] next_read_byte;

	always_comb
	begin
		next_state      = state;
		next_req        = flash_req;
		next_strobe     = 1'b0;
		next_finish     = 1'b0;
		next_read_valid = 1'b0;
		next_read_byte  = read_byte;
		case (state)
			SEQ_IDLE:
			begin
				if (start)
				begin
					next_req   = request;
					next_state = SEQ_ISSUE;
				end
			end
			SEQ_ISSUE:
			begin
				next_strobe = 1'b1;
				next_state  = SEQ_WAIT;
			end
			SEQ_WAIT:
			begin
				if (flash_done)
				begin
					next_finish = 1'b1;
					if (flash_req.op == `OP_READ)
					begin
						next_read_valid = 1'b1;
						next_read_byte  = flash_rdata;
					end
					// release the array: chip enable off between operations
					next_req.ce_n = 1'b1;
					next_req.oe   = 1'b0;
					next_state    = SEQ_IDLE;
				end
			end
			default:
				next_state = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state        <= SEQ_IDLE;
			flash_req    <= '{bank: 1'b0, oe: 1'b0, ce_n: 1'b1, op: `OP_READ,
			                  addr: 16'h0000, wdata: 8'h00};
			flash_strobe <= 1'b0;
			busy         <= 1'b0;
			finish       <= 1'b0;
			read_valid   <= 1'b0;
			read_byte    <= 8'h00;
		end
		else
		begin
			state        <= next_state;
			flash_req    <= next_req;
			flash_strobe <= next_strobe;
			busy         <= (next_state != SEQ_IDLE);
			finish       <= next_finish;
			read_valid   <= next_read_valid;
			read_byte    <= next_read_byte;
		end
	end

endmodule

// ### core/isp_flash_timed_access.sv
// Function
// - first key value starts a countdown expiring after three machine cycles
// - second key before expiry opens a three machine cycle write window
// - window closes by itself; full two-write sequence needed again
// - protected writes land only while window open, else silently dropped
// - chip program control and clock select control are protected registers
// - chip program control read-only by default; other key values revoke permission
// - chip program bit 0 enters programming mode at next idle wake-up
// - that wake-up fetches from loader bank and pulses the vector load output
// - bits 0, 1 and 7 together soft-reset the cpu back to application bank
// - 64 KB application bank, 4 KB loader bank, normal run from application
// - target address comes from high-byte and low-byte registers
// - command bit 6 selects bank: 0 application, 1 loader
// - command bits: 5 output enable, 4 chip enable, 3..0 operation code
// - codes erase 0010, program 0001, read 0000; enables per table
// - data register feeds program byte and returns read byte; erase ignores them
`timescale 1ns/1ps
`include "isp_flash_cfg.svh"

module isp_flash_timed_access
	import isp_flash_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cpu_idle,
	output logic             cpu_wake,
	output logic             cpu_soft_reset,
	output logic             isp_vector_load,
	output logic             fetch_from_loader,
	output logic [7:0]       clock_select,
	output flash_req_t       flash_req,
	output logic             flash_strobe,
	input  wire logic        flash_done,
	input  wire logic [7:0]  flash_rdata
);

	logic [7:0] chip_program_control;
	logic [7:0] clock_select_control;
	logic [7:0] flash_command_control;
	logic [7:0] flash_addr_high;
	logic [7:0] flash_addr_low;
	logic [7:0] flash_data_byte;
	logic       isp_mode;
	logic       idle_prev;
	logic       op_pending;

	logic [7:0] next_chip_program_control;
	logic [7:0] next_clock_select_control;
	logic [7:0] next_flash_command_control;
	logic [7:0] next_flash_addr_high;
	logic [7:0] next_flash_addr_low;
	logic [7:0] next_flash_data_byte;
	logic       next_isp_mode;
	logic       next_op_pending;
	logic       next_cpu_wake;
	logic       next_cpu_soft_reset;
	logic       next_isp_vector_load;
	logic [31:0] next_prdata;
	logic       next_pready;
	logic       next_pslverr;

	logic        setup;
	logic        wr_access;
	logic [7:0]  reg_index;
	logic        addr_word;
	logic        hit_cmd;
	logic        hit_key;
	logic        hit_ah;
	logic        hit_al;
	logic        hit_fd;
	logic        hit_chp;
	logic        hit_cks;
	logic        mapped;
	logic [7:0]  wbyte;
	logic        window_open;
	logic        idle_rise;
	logic        seq_start;
	flash_req_t  op_request;
	logic        seq_busy;
	logic        seq_finish;
	logic        seq_read_valid;
	logic [7:0]  seq_read_byte;
	logic        soft_reset_hit;
	logic [3:0]  op_code;
	logic        op_legal;
	logic [15:0] op_addr;

	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite && pready;
	assign reg_index = paddr[9:2];
	assign addr_word = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	assign hit_cmd   = addr_word && (reg_index == `IDX_CMD);
	assign hit_key   = addr_word && (reg_index == `IDX_KEY);
	assign hit_ah    = addr_word && (reg_index == `IDX_ADDR_HIGH);
	assign hit_al    = addr_word && (reg_index == `IDX_ADDR_LOW);
	assign hit_fd    = addr_word && (reg_index == `IDX_DATA);
	assign hit_chp   = addr_word && (reg_index == `IDX_CHIP_PROG);
	assign hit_cks   = addr_word && (reg_index == `IDX_CLK_SEL);
	assign mapped    = hit_cmd || hit_key || hit_ah || hit_al || hit_fd || hit_chp || hit_cks;
	assign wbyte     = pwdata[7:0];

	timed_access_gate u_gate
	(
		.clock       (clock),
		.sys_rst     (sys_rst),
		.key_write   (wr_access && hit_key),
		.key_value   (wbyte),
		.window_open (window_open)
	);

	// operation decode from the command register
	assign op_code  = flash_command_control[`CMD_OP_MSB:0];
	assign op_legal = (op_code == `OP_ERASE) || (op_code == `OP_PROGRAM) || (op_code == `OP_READ);
	// loader bank spans 4 KB, so the upper address bits fold away there
	assign op_addr  = flash_command_control[`CMD_BANK_BIT]
		? ({flash_addr_high, flash_addr_low} & `LOADER_ADDR_MASK)
		: {flash_addr_high, flash_addr_low};

	always_comb
	begin
		op_request.bank  = flash_command_control[`CMD_BANK_BIT];
		op_request.oe    = flash_command_control[`CMD_OE_BIT];
		op_request.ce_n  = flash_command_control[`CMD_CE_BIT];
		op_request.op    = op_code;
		op_request.addr  = op_addr;
		op_request.wdata = flash_data_byte;
		if (op_code == `OP_ERASE)
		begin
			op_request.addr  = 16'h0000;
			op_request.wdata = 8'h00;
		end
	end

	assign idle_rise      = cpu_idle && !idle_prev;
	assign seq_start      = op_pending && !seq_busy;
	assign soft_reset_hit = wr_access && hit_chp && window_open && wbyte[`CHP_ISP_BIT]
		&& wbyte[`CHP_RST_BIT_A] && wbyte[`CHP_RST_BIT_B];

	flash_op_sequencer u_seq
	(
		.clock        (clock),
		.sys_rst      (sys_rst),
		.start        (seq_start),
		.request      (op_request),
		.flash_done   (flash_done),
		.flash_rdata  (flash_rdata),
		.flash_req    (flash_req),
		.flash_strobe (flash_strobe),
		.busy         (seq_busy),
		.finish       (seq_finish),
		.read_valid   (seq_read_valid),
		.read_byte    (seq_read_byte)
	);

	// register writes, idle handling and wake-up
	always_comb
	begin
		next_chip_program_control  = chip_program_control;
		next_clock_select_control  = clock_select_control;
		next_flash_command_control = flash_command_control;
		next_flash_addr_high       = flash_addr_high;
		next_flash_addr_low        = flash_addr_low;
		next_flash_data_byte       = flash_data_byte;
		next_isp_mode              = isp_mode;
		next_op_pending            = op_pending && !seq_start;
		next_cpu_wake              = 1'b0;
		next_cpu_soft_reset        = 1'b0;
		next_isp_vector_load       = 1'b0;

		if (wr_access)
		begin
			if (hit_chp && window_open)
				next_chip_program_control = wbyte;
			if (hit_cks && window_open)
				next_clock_select_control = wbyte;
			// command and operand registers are frozen while the array is busy
			if (!seq_busy && !op_pending)
			begin
				if (hit_cmd)
					next_flash_command_control = wbyte & `CMD_WR_MASK;
				if (hit_ah)
					next_flash_addr_high = wbyte;
				if (hit_al)
					next_flash_addr_low = wbyte;
				if (hit_fd)
					next_flash_data_byte = wbyte;
			end
		end

		if (seq_read_valid)
			next_flash_data_byte = seq_read_byte;

		if (idle_rise && !soft_reset_hit)
		begin
			if (!isp_mode && chip_program_control[`CHP_ISP_BIT])
			begin
				next_isp_mode        = 1'b1;
				next_isp_vector_load = 1'b1;
				next_cpu_wake        = 1'b1;
			end
			else if (isp_mode)
			begin
				// a disabled chip or unknown code completes at once
				if (op_legal && !flash_command_control[`CMD_CE_BIT])
					next_op_pending = 1'b1;
				else
					next_cpu_wake = 1'b1;
			end
		end

		if (seq_finish)
			next_cpu_wake = 1'b1;

		if (soft_reset_hit)
		begin
			next_cpu_soft_reset       = 1'b1;
			next_isp_mode             = 1'b0;
			next_chip_program_control = `REG_RESET;
			next_op_pending           = 1'b0;
		end
	end

	// apb answer: read data and ready are set up in the setup cycle
	always_comb
	begin
		next_prdata  = 32'h0000_0000;
		next_pready  = setup;
		next_pslverr = setup && !mapped;
		if (setup && !pwrite)
		begin
			if (hit_cmd)
				next_prdata[7:0] = flash_command_control;
			if (hit_ah)
				next_prdata[7:0] = flash_addr_high;
			if (hit_al)
				next_prdata[7:0] = flash_addr_low;
			if (hit_fd)
				next_prdata[7:0] = flash_data_byte;
			if (hit_chp)
				next_prdata[7:0] = chip_program_control;
			if (hit_cks)
				next_prdata[7:0] = clock_select_control;
			if (hit_key)
				next_prdata[7:0] = {7'h00, window_open};
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			chip_program_control  <= `REG_RESET;
			clock_select_control  <= `REG_RESET;
			flash_command_control <= `REG_RESET;
			flash_addr_high       <= `REG_RESET;
			flash_addr_low        <= `REG_RESET;
			flash_data_byte       <= `REG_RESET;
			isp_mode              <= 1'b0;
			idle_prev             <= 1'b0;
			op_pending            <= 1'b0;
			cpu_wake              <= 1'b0;
			cpu_soft_reset        <= 1'b0;
			isp_vector_load       <= 1'b0;
			fetch_from_loader     <= 1'b0;
			clock_select          <= `REG_RESET;
			prdata                <= 32'h0000_0000;
			pready                <= `PREADY_BUSY;
			pslverr               <= 1'b0;
		end
		else
		begin
			chip_program_control  <= next_chip_program_control;
			clock_select_control  <= next_clock_select_control;
			flash_command_control <= next_flash_command_control;
			flash_addr_high       <= next_flash_addr_high;
			flash_addr_low        <= next_flash_addr_low;
			flash_data_byte       <= next_flash_data_byte;
			isp_mode              <= next_isp_mode;
			idle_prev             <= cpu_idle;
			op_pending            <= next_op_pending;
			cpu_wake              <= next_cpu_wake;
			cpu_soft_reset        <= next_cpu_soft_reset;
			isp_vector_load       <= next_isp_vector_load;
			fetch_from_loader     <= next_isp_mode;
			clock_select          <= next_clock_select_control;
			prdata                <= next_prdata;
			pready                <= next_pready;
			pslverr               <= next_pslverr;
		end
	end

endmodule

// ### dv/isp_flash_props.sv
`timescale 1ns/1ps
`include "isp_flash_cfg.svh"
module isp_flash_props
	import isp_flash_pkg::*;
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        cpu_idle,
	input wire logic        cpu_wake,
	input wire logic        cpu_soft_reset,
	input wire logic        isp_vector_load,
	input wire logic        fetch_from_loader,
	input flash_req_t       flash_req,
	input wire logic        flash_strobe,
	input wire logic        flash_done
);
	logic op_live;
	logic next_op_live;
	always_comb
	begin
		next_op_live = op_live;
		if (flash_strobe)
			next_op_live = 1'b1;
		else if (flash_done)
			next_op_live = 1'b0;
	end
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			op_live <= 1'b0;
		else
			op_live <= next_op_live;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_strobe_legal_op: assert property (flash_strobe |-> !flash_req.ce_n &&
		flash_req.op inside {`OP_ERASE, `OP_PROGRAM, `OP_READ}) else $error("bad strobe");
	a_erase_no_data: assert property (flash_strobe && flash_req.op == `OP_ERASE
		|-> flash_req.addr == 16'h0000 && flash_req.wdata == 8'h00) else $error("erase data");
	a_loader_addr_mask: assert property (flash_strobe && flash_req.bank
		|-> flash_req.addr[15:12] == 4'h0) else $error("loader address too wide");
	a_isp_vector_wake: assert property (isp_vector_load
		|-> cpu_wake && fetch_from_loader) else $error("vector load without wake");
	a_loader_entry: assert property ($rose(fetch_from_loader)
		|-> isp_vector_load) else $error("loader fetch without entry");
	a_soft_reset_app: assert property (cpu_soft_reset
		|-> !fetch_from_loader) else $error("soft reset left loader fetch");
	a_done_wakes: assert property (op_live && flash_done |=> ##1 cpu_wake)
		else $error("no wake after done");
	a_req_held: assert property (op_live |-> $stable(flash_req))
		else $error("request changed mid operation");
	a_wake_one_cycle: assert property (cpu_wake |=> !cpu_wake)
		else $error("wake longer than a cycle");
	c_read_op: cover property (flash_strobe && flash_req.op == `OP_READ);
	c_isp_entry: cover property (isp_vector_load);
	c_soft_reset: cover property (cpu_soft_reset);
endmodule

bind isp_flash_timed_access isp_flash_props u_isp_flash_props (.clock, .sys_rst, .psel,
	.penable, .cpu_idle, .cpu_wake, .cpu_soft_reset, .isp_vector_load, .fetch_from_loader,
	.flash_req, .flash_strobe, .flash_done);

// ### dv/flash_array_model.sv
`timescale 1ns/1ps
`include "isp_flash_cfg.svh"
module flash_array_model
	import isp_flash_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  flash_req_t      flash_req,
	input  wire logic       flash_strobe,
	input  wire logic [2:0] lat,
	output logic            flash_done,
	output logic [7:0]      flash_rdata
);
	logic [7:0] app[int];
	logic [7:0] ldr[int];
	flash_req_t req;
	int         cnt;
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt = -1;
			flash_done <= 1'b0;
			flash_rdata <= 8'h00;
		end
		else
		begin
			flash_done <= 1'b0;
			// data lines are not held outside a read answer
			flash_rdata <= ~flash_rdata;
			if (flash_strobe)
			begin
				req = flash_req;
				cnt = int'(lat);
			end
			else if (cnt > 0)
				cnt--;
			else if (cnt == 0)
			begin
				cnt = -1;
				flash_done <= 1'b1;
				case (req.op)
					`OP_ERASE: if (req.bank) ldr.delete(); else app.delete();
					`OP_PROGRAM: if (req.bank) ldr[req.addr[11:0]] = req.wdata;
						else app[req.addr] = req.wdata;
					`OP_READ: if (req.bank) flash_rdata <= ldr.exists(req.addr[11:0]) ?
							ldr[req.addr[11:0]] : 8'hff;
						else flash_rdata <= app.exists(req.addr) ? app[req.addr] : 8'hff;
					default: flash_done <= 1'b0;
				endcase
			end
		end
	end
endmodule

// ### dv/isp_flash_timed_access_bench.sv
`timescale 1ns/1ps
`include "isp_flash_cfg.svh"
module isp_flash_timed_access_bench
	import isp_flash_pkg::*;
;
	localparam logic [11:0] A_CMD = {2'b0, `IDX_CMD, 2'b0};
	localparam logic [11:0] A_KEY = {2'b0, `IDX_KEY, 2'b0};
	localparam logic [11:0] A_AH = {2'b0, `IDX_ADDR_HIGH, 2'b0};
	localparam logic [11:0] A_AL = {2'b0, `IDX_ADDR_LOW, 2'b0};
	localparam logic [11:0] A_DAT = {2'b0, `IDX_DATA, 2'b0};
	localparam logic [11:0] A_CHP = {2'b0, `IDX_CHIP_PROG, 2'b0};
	localparam logic [11:0] A_CLK = {2'b0, `IDX_CLK_SEL, 2'b0};
	logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, cpu_idle, cpu_wake;
	logic        cpu_soft_reset, isp_vector_load, fetch_from_loader, flash_strobe, flash_done;
	logic        bk;
	logic [2:0]  lat;
	logic [7:0]  clock_select, flash_rdata, d, ck;
	logic [11:0] paddr;
	logic [15:0] a, ea;
	logic [31:0] pwdata, prdata;
	flash_req_t  flash_req;
	logic [32:0] exp_q[$];
	int          error_cnt, tests_run, strobes, s, sr_cnt;

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	isp_flash_timed_access u_isp_flash_timed_access (.clock, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_idle, .cpu_wake,
		.cpu_soft_reset, .isp_vector_load, .fetch_from_loader, .clock_select, .flash_req,
		.flash_strobe, .flash_done, .flash_rdata);
	flash_array_model u_flash_array_model (.clock, .sys_rst, .flash_req, .flash_strobe,
		.lat, .flash_done, .flash_rdata);

	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("unexpected %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic test_done;
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] v);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h0, v};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
			error_cnt++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] ad, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, ad, 8'h00);
	endtask
	task automatic unlock;
		apb(1'b1, A_KEY, `KEY_FIRST);
		apb(1'b1, A_KEY, `KEY_SECOND);
	endtask
	// cpu idles until the block wakes it; a strobe seen meanwhile has its bank, op and address checked
	task automatic idle_op(input logic b, input logic [3:0] op, input logic [15:0] x);
		int n;
		lat <= 3'($urandom);
		cpu_idle <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
			if (flash_strobe === 1'b1)
			begin
				strobes++;
				chk("flash_req", {12'h0, b, op, x}, 33'({flash_req.bank, flash_req.op, flash_req.addr}));
			end
		end
		while (cpu_wake !== 1'b1 && n < 40);
		chk("cpu_wake", 33'h1, 33'(cpu_wake));
		cpu_idle <= 1'b0;
		@(posedge clock);
	endtask

	always @(posedge clock)
	begin
		if (psel && penable && pready && !pwrite)
			chk("prdata", exp_q.pop_front(), {pslverr, prdata});
		if (cpu_soft_reset === 1'b1)
			sr_cnt++;
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, cpu_idle, lat} = '0;
		{error_cnt, tests_run, strobes, sr_cnt} = '0;
		sys_rst = 1'b1;
		void'($urandom(97));
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(A_KEY, 33'h0);
		rd(12'h004, 33'h1_0000_0000);
		ck = 8'($urandom) | 8'h01;
		apb(1'b1, A_CLK, ck);
		chk("clock_select", 33'h0, 33'(clock_select));
		unlock();
		rd(A_KEY, 33'h1);
		apb(1'b1, A_CLK, ck);
		chk("clock_select", 33'(ck), 33'(clock_select));
		repeat (`TA_WIN_CLKS) @(posedge clock);
		rd(A_KEY, 33'h0);
		apb(1'b1, A_CLK, ~ck);
		chk("clock_select", 33'(ck), 33'(clock_select));
		apb(1'b1, A_KEY, `KEY_FIRST);
		repeat (`TA_ARM_CLKS) @(posedge clock);
		apb(1'b1, A_KEY, `KEY_SECOND);
		rd(A_KEY, 33'h0);
		unlock();
		apb(1'b1, A_KEY, 8'h11);
		rd(A_KEY, 33'h0);
		apb(1'b1, A_CLK, ~ck);
		chk("clock_select", 33'(ck), 33'(clock_select));
		unlock();
		apb(1'b1, A_CHP, 8'h01);
		idle_op(1'b0, 4'h0, 16'h0);
		chk("fetch_from_loader", 33'h1, 33'(fetch_from_loader));
		d = 8'($urandom);
		a = 16'($urandom);
		for (int i = 0; i < 2; i++)
		begin
			bk = i[0];
			ea = bk ? (a & `LOADER_ADDR_MASK) : a;
			apb(1'b1, A_CMD, {1'b0, bk, 2'b10, `OP_ERASE});
			idle_op(bk, `OP_ERASE, 16'h0);
			apb(1'b1, A_AH, a[15:8]);
			apb(1'b1, A_AL, a[7:0]);
			apb(1'b1, A_DAT, d);
			apb(1'b1, A_CMD, {1'b0, bk, 2'b10, `OP_PROGRAM});
			idle_op(bk, `OP_PROGRAM, ea);
			apb(1'b1, A_AH, a[15:8] ^ {bk, 7'h0});
			apb(1'b1, A_CMD, {1'b0, bk, 2'b00, `OP_READ});
			idle_op(bk, `OP_READ, ea);
			rd(A_DAT, 33'(d));
		end
		s = strobes;
		apb(1'b1, A_CMD, 8'h10);
		idle_op(1'b0, 4'h0, 16'h0);
		apb(1'b1, A_CMD, 8'h05);
		idle_op(1'b0, 4'h0, 16'h0);
		chk("flash_strobe", 33'(s), 33'(strobes));
		unlock();
		apb(1'b1, A_CHP, 8'h83);
		@(posedge clock);
		chk("cpu_soft_reset", 33'h1, 33'(sr_cnt));
		chk("fetch_from_loader", 33'h0, 33'(fetch_from_loader));
		test_done();
	end

	initial
	begin
		#200000;
		error_cnt++;
		test_done();
	end
endmodule
